// ==== logic/cic_defines.vh ====
`ifndef CIC_DEFINES_VH
`define CIC_DEFINES_VH

// I/O port addresses of the two controllers
`define CIC_MASTER_CMD 16'h0020
`define CIC_MASTER_DATA 16'h0021
`define CIC_SLAVE_CMD 16'h00A0
`define CIC_SLAVE_DATA 16'h00A1
// Interrupt-in-progress latch port, status in bit 0
`define CIC_IIP_PORT 16'h00E0
`define CIC_IIP_BIT 0
// Legacy sharing reset ports, upper twelve address bits
`define CIC_SHARE_LO 12'h02F
`define CIC_SHARE_HI 12'h06F

// Vector bases after reset, upper five vector bits
`define CIC_MASTER_BASE 5'h01
`define CIC_SLAVE_BASE 5'h0E
// Master input fed by the slave, slave input replacing it
`define CIC_CASCADE_LVL 3'h2
`define CIC_REPLACE_LVL 3'h1
// Level reported when nothing is pending
`define CIC_SPURIOUS_LVL 3'h7

// Command byte decoding
`define CIC_ICW1_BIT 4
`define CIC_OCW3_BIT 3
`define CIC_EOI_NONSPEC 3'h1
`define CIC_EOI_SPEC 3'h3

// Initialisation sequence steps
`define CIC_STEP_READY 2'h0
`define CIC_STEP_ICW2 2'h1
`define CIC_STEP_ICW3 2'h2
`define CIC_STEP_ICW4 2'h3

`endif

// ==== logic/cic_core.v ====
`include "cic_defines.vh"

module cic_core #(
	parameter [4:0] BASE_RESET = 5'h01
) (
	input wire clk,
	input wire rst,
	input wire cmd_wr,
	input wire cmd_a0,
	input wire [7:0] cmd_data,
	input wire [7:0] edge_req,
	input wire [7:0] level_req,
	input wire ack,
	output wire int_out,
	output reg [2:0] pick,
	output wire [7:0] vector,
	output wire [7:0] rd_data
);

	reg [7:0] irr_edge_q; // Latched edge requests
	reg [7:0] prev_q; // Edge request levels last cycle
	reg [7:0] isr_q; // In-service bits
	reg [7:0] mask_q; // Interrupt mask
	reg [4:0] base_q; // Vector base
	reg [1:0] step_q; // Initialisation step
	reg need_icw4_q; // Fourth init byte expected
	reg read_isr_q; // Command port reads in-service
	reg pend_any; // Some unmasked request pending
	reg [3:0] top_isr; // Highest level in service, 8 if none
	integer i;

	// Level inputs count only while held, edge inputs once latched
	wire [7:0] irr = irr_edge_q | level_req;
	wire [7:0] pending = irr & ~mask_q;
	wire [7:0] rise = edge_req & ~prev_q;
	wire is_icw1 = cmd_wr & ~cmd_a0 & cmd_data[`CIC_ICW1_BIT];
	wire is_ocw2 = cmd_wr & ~cmd_a0 & ~cmd_data[`CIC_ICW1_BIT] & ~cmd_data[`CIC_OCW3_BIT];
	wire is_ocw3 = cmd_wr & ~cmd_a0 & ~cmd_data[`CIC_ICW1_BIT] & cmd_data[`CIC_OCW3_BIT];

	////////////////////////////////////////////////////////////////////////////
	// Fixed priority, level 0 highest
	always @* begin
		pick = `CIC_SPURIOUS_LVL;
		pend_any = 1'b0;
		top_isr = 4'h8;
		for (i = 7; i >= 0; i = i - 1) begin
			if (pending[i]) begin
				pick = i[2:0];
				pend_any = 1'b1;
			end
			if (isr_q[i])
				top_isr = i[3:0];
		end
	end

	// Fully nested: only a level above all in-service ones interrupts
	assign int_out = pend_any && ({1'b0, pick} < top_isr);
	assign vector = {base_q, pick};
	assign rd_data = cmd_a0 ? mask_q : (read_isr_q ? isr_q : irr);

	////////////////////////////////////////////////////////////////////////////
	// Request latching and in-service handling
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			irr_edge_q <= 8'h00;
			prev_q <= 8'h00;
			isr_q <= 8'h00;
		end else begin
			prev_q <= edge_req;
			if (is_icw1) begin
				// Initialisation clears all history
				irr_edge_q <= 8'h00;
				isr_q <= 8'h00;
			end else begin
				// edge latching
				// An empty acknowledge must not drop a masked edge on level 7
				irr_edge_q <= (irr_edge_q & ~((ack && pend_any ? 8'h01 : 8'h00) << pick)) | rise;
				if (is_ocw2 && cmd_data[7:5] == `CIC_EOI_NONSPEC && !top_isr[3])
					isr_q[top_isr[2:0]] <= 1'b0;
				else if (is_ocw2 && cmd_data[7:5] == `CIC_EOI_SPEC)
					isr_q[cmd_data[2:0]] <= 1'b0;
				// Acknowledge comes last so a same-cycle set beats the clear
				if (ack && pend_any)
					isr_q[pick] <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// command sequencing
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			mask_q <= 8'h00;
			base_q <= BASE_RESET;
			step_q <= `CIC_STEP_READY;
			need_icw4_q <= 1'b0;
			read_isr_q <= 1'b0;
		end else if (is_icw1) begin
			mask_q <= 8'h00;
			step_q <= `CIC_STEP_ICW2;
			need_icw4_q <= cmd_data[0];
			read_isr_q <= 1'b0;
		end else if (is_ocw3 && cmd_data[1]) begin
			read_isr_q <= cmd_data[0];
		end else if (cmd_wr && cmd_a0) begin
			case (step_q)
				`CIC_STEP_ICW2: begin
					base_q <= cmd_data[7:3];
					step_q <= `CIC_STEP_ICW3;
				end
				`CIC_STEP_ICW3: begin
					// Cascade wiring is fixed, byte is accepted and dropped
					step_q <= need_icw4_q ? `CIC_STEP_ICW4 : `CIC_STEP_READY;
				end
				`CIC_STEP_ICW4: begin
					step_q <= `CIC_STEP_READY;
				end
				default: begin
					mask_q <= cmd_data;
				end
			endcase
		end
	end

endmodule // cic_core

// ==== logic/cascaded_interrupt_controller.v ====
// Behaviour
// - Keep standard controller command and status
// - PCI requests level, expansion requests edge
// - End of interrupt clears serviced bit
// - End of interrupt acts whatever request state
// - Still-held level request raises again
// - Readable interrupt-in-progress latch bit
// - Expansion line 2 routed to level 9
// - Level 9 vector 71, level 2 0A
// - Sharing reset ports cause no disturbance

`include "cic_defines.vh"

module cascaded_interrupt_controller (
	input wire clk,
	input wire rst,
	// Processor I/O cycle, one cycle strobes
	input wire [15:0] io_addr,
	input wire io_wr,
	input wire io_rd,
	input wire [7:0] io_wdata,
	output reg [7:0] io_rdata,
	// Interrupt request and acknowledge
	output wire cpu_intr,
	input wire cpu_inta,
	output reg [7:0] cpu_vector,
	// Device request lines, one per level
	input wire [15:0] exp_irq,
	input wire [15:0] pci_irq
);

	////////////////////////////////////////////////////////////////////////////
	// Port decode

	// Rows of the I/O map this block answers to
	wire hit_m_cmd = io_addr == `CIC_MASTER_CMD;
	wire hit_m_data = io_addr == `CIC_MASTER_DATA;
	wire hit_s_cmd = io_addr == `CIC_SLAVE_CMD;
	wire hit_s_data = io_addr == `CIC_SLAVE_DATA;
	wire hit_iip = io_addr == `CIC_IIP_PORT;
	// sharing ports ignored
	// Old shared-edge software still pokes these; they must fall through
	// without reaching either controller or the latch.
	wire hit_share = io_addr[15:4] == `CIC_SHARE_LO || io_addr[15:4] == `CIC_SHARE_HI;

	// Per-controller command strobes, never raised by a sharing port
	wire m_wr = io_wr & ~hit_share & (hit_m_cmd | hit_m_data);
	wire s_wr = io_wr & ~hit_share & (hit_s_cmd | hit_s_data);

	////////////////////////////////////////////////////////////////////////////
	// Request routing

	wire s_int; // Slave combined request
	wire m_int; // Master combined request
	wire [2:0] m_pick; // Master chosen level
	wire [2:0] s_pick; // Slave chosen level, unused outside vectors
	wire [7:0] m_vector; // Master vector for chosen level
	wire [7:0] s_vector; // Slave vector for chosen level
	wire [7:0] m_rd; // Master read data
	wire [7:0] s_rd; // Slave read data

	// line 2 to level 9
	// The slave's replacement input carries both line 2 and line 9, so a
	// card strapped to either one interrupts through the same level.
	wire [7:0] s_edge = {exp_irq[15:10],
		exp_irq[9] | exp_irq[2], exp_irq[8]};
	wire [7:0] s_level = {pci_irq[15:10],
		pci_irq[9] | pci_irq[2], pci_irq[8]};

	// slave into master input
	// The slave's output is a level, so the master sees it as a held request;
	// the line-2 pins never reach the master directly.
	wire [7:0] m_edge = {exp_irq[7:3], 1'b0, exp_irq[1:0]};
	wire [7:0] m_level = {pci_irq[7:3], s_int, pci_irq[1:0]};

	// Slave is acknowledged only when the master passes it the cycle
	wire to_slave = m_int && m_pick == `CIC_CASCADE_LVL;
	wire m_ack = cpu_inta;
	wire s_ack = cpu_inta & to_slave;

	////////////////////////////////////////////////////////////////////////////
	// Controllers

	// vector bases
	// Reset bases place level 2 on 0A and level 9 on 71 until
	// software reprograms them with a new initialisation sequence.
	cic_core #(
		.BASE_RESET(`CIC_MASTER_BASE)
	) master_ctl (
		.clk(clk),
		.rst(rst),
		.cmd_wr(m_wr),
		.cmd_a0(hit_m_data),
		.cmd_data(io_wdata),
		.edge_req(m_edge),
		.level_req(m_level),
		.ack(m_ack),
		.int_out(m_int),
		.pick(m_pick),
		.vector(m_vector),
		.rd_data(m_rd)
	);

	// held level reasserts
	// A level input is pending for as long as the pin is high, so once the
	// end of interrupt frees its level it interrupts again straight away.
	cic_core #(
		.BASE_RESET(`CIC_SLAVE_BASE)
	) slave_ctl (
		.clk(clk),
		.rst(rst),
		.cmd_wr(s_wr),
		.cmd_a0(hit_s_data),
		.cmd_data(io_wdata),
		.edge_req(s_edge),
		.level_req(s_level),
		.ack(s_ack),
		.int_out(s_int),
		.pick(s_pick),
		.vector(s_vector),
		.rd_data(s_rd)
	);

	// Request to the processor follows the master directly
	assign cpu_intr = m_int;

	////////////////////////////////////////////////////////////////////////////
	// Vector register

	// Captured on acknowledge; holds until the next acknowledge
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cpu_vector <= 8'h00;
		end else if (cpu_inta) begin
			if (to_slave)
				cpu_vector <= s_vector;
			else
				cpu_vector <= m_vector;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Interrupt-in-progress latch

	reg iip_q; // Set by acknowledge, cleared by read or write of its port
	wire iip_rd = io_rd & hit_iip;
	wire iip_wr = io_wr & hit_iip;

	// in-progress latch
	// Both clearing styles are offered: the read that reports it, or an
	// explicit write. An acknowledge in the same cycle wins, so a new
	// interrupt is never hidden by a racing clear.
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			iip_q <= 1'b0;
		end else if (cpu_inta) begin
			iip_q <= 1'b1;
		end else if (iip_rd || iip_wr) begin
			iip_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data

	// Registered a cycle after the read strobe; unmapped ports read zero
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			io_rdata <= 8'h00;
		end else if (io_rd) begin
			if (hit_m_cmd || hit_m_data)
				io_rdata <= m_rd;
			else if (hit_s_cmd || hit_s_data)
				io_rdata <= s_rd;
			else if (hit_iip)
				io_rdata <= {7'h00, iip_q} << `CIC_IIP_BIT;
			else
				io_rdata <= 8'h00;
		end
	end

endmodule // cascaded_interrupt_controller

// ==== verification/cic_cpu_model.sv ====
// Processor side: answers a raised request with one acknowledge pulse
module cic_cpu_model (
	input wire clk,
	input wire rst,
	input wire cpu_intr,
	input wire req,
	output logic cpu_inta
);
	timeunit 1ns;
	timeprecision 1ps;
	logic busy_q; // Pulse already given for this request

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cpu_inta <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			// Never acknowledges while the request line is low
			cpu_inta <= req && cpu_intr && !busy_q;
			busy_q <= req && (busy_q || cpu_intr);
		end
	end
endmodule // cic_cpu_model

// ==== verification/cascaded_interrupt_controller_properties.sv ====
// Watches the controller ports; no init sequence is assumed, bases stay at reset
module cic_properties (
	input wire clk,
	input wire rst,
	input wire [15:0] io_addr,
	input wire io_wr,
	input wire io_rd,
	input wire [7:0] io_wdata,
	input wire [7:0] io_rdata,
	input wire cpu_intr,
	input wire cpu_inta,
	input wire [7:0] cpu_vector,
	input wire [15:0] exp_irq,
	input wire [15:0] pci_irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	logic iip_q; // Expected latch; set beats clear
	wire iip_rd = io_rd && !io_wr && io_addr == 16'h00E0 && !cpu_inta;
	wire share = io_addr[15:4] == 12'h02F || io_addr[15:4] == 12'h06F;

	// Latch model
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			iip_q <= 1'b0;
		end else if (cpu_inta) begin
			iip_q <= 1'b1;
		end else if ((io_rd || io_wr) && io_addr == 16'h00E0) begin
			iip_q <= 1'b0;
		end
	end

	a_vector_held: assert property (!cpu_inta |=> $stable(cpu_vector))
		else $error("vector moved without ack");
	a_rdata_held: assert property (!io_rd |=> $stable(io_rdata))
		else $error("read data moved without read");
	a_share_silent: assert property (io_rd && share |=> io_rdata == 8'h00)
		else $error("sharing port read not zero");
	a_unmapped_zero: assert property (io_rd && io_addr[15:8] == 8'h03 |=> io_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_mask_readback: assert property (io_wr && io_addr == 16'h0021 ##2 io_rd && !io_wr
		&& io_addr == 16'h0021 |=> io_rdata == $past(io_wdata, 3))
		else $error("mask read back wrong");
	a_iip_set: assert property (iip_rd && iip_q |=> io_rdata[0])
		else $error("latch not set after ack");
	a_iip_clear: assert property (iip_rd && !iip_q |=> !io_rdata[0])
		else $error("latch not cleared");
	a_vector_base: assert property (cpu_inta && cpu_intr |=>
		cpu_vector[7:3] == 5'h01 || cpu_vector[7:3] == 5'h0E)
		else $error("vector outside reset bases");

	cover property (cpu_inta && cpu_intr);
	cover property (iip_rd && iip_q);
	cover property (io_wr && share);
endmodule // cic_properties

bind cascaded_interrupt_controller cic_properties chk (.clk(clk), .rst(rst), .io_addr(io_addr),
	.io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
	.cpu_intr(cpu_intr), .cpu_inta(cpu_inta), .cpu_vector(cpu_vector),
	.exp_irq(exp_irq), .pci_irq(pci_irq));

// ==== verification/cascaded_interrupt_controller_bench.sv ====
module cascaded_interrupt_controller_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst, io_wr, io_rd, cpu_inta, cpu_intr, req;
	logic [15:0] io_addr, exp_irq, pci_irq;
	logic [7:0] io_wdata, io_rdata, cpu_vector, d;
	int failures, checks;
	// Rows: expansion line and the vector it must give
	int lines [8] = '{0, 1, 2, 3, 7, 8, 9, 15};
	logic [7:0] vecs [8] = '{8'h08, 8'h09, 8'h71, 8'h0B, 8'h0F, 8'h70, 8'h71, 8'h77};

	cascaded_interrupt_controller uut (.clk(clk), .rst(rst), .io_addr(io_addr), .io_wr(io_wr),
		.io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .cpu_intr(cpu_intr),
		.cpu_inta(cpu_inta), .cpu_vector(cpu_vector), .exp_irq(exp_irq), .pci_irq(pci_irq));
	cic_cpu_model cpu (.clk(clk), .rst(rst), .cpu_intr(cpu_intr), .req(req), .cpu_inta(cpu_inta));

	////////////////////////////////////////////////////////////////////////
	task check(input logic [7:0] seen, input logic [7:0] want);
		checks++;
		if (seen !== want) begin
			failures++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	// One-cycle write strobe
	task io_w(input logic [15:0] a, input logic [7:0] v);
		@(posedge clk);
		io_addr <= a;
		io_wdata <= v;
		io_wr <= 1'b1;
		@(posedge clk);
		io_wr <= 1'b0;
		#1;
	endtask
	// Data is there one cycle after the strobe edge
	task io_r(input logic [15:0] a);
		@(posedge clk);
		io_addr <= a;
		io_rd <= 1'b1;
		@(posedge clk);
		io_rd <= 1'b0;
		#1 d = io_rdata;
	endtask
	// Bounded wait for the processor pulse, then vector and drop of request
	task ack(input logic [7:0] want);
		int n;
		n = 0;
		@(posedge clk);
		req <= 1'b1;
		while (cpu_inta !== 1'b1 && n < 20) begin
			@(posedge clk);
			#1 n++;
		end
		@(posedge clk);
		req <= 1'b0;
		#1 check(cpu_vector, want);
		check({7'h00, cpu_intr}, 8'h00);
	endtask
	task conclude();
		if (failures == 0 && checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Watchdog well beyond the run length
	initial begin
		#200000;
		failures++;
		conclude();
	end
	initial begin
		{rst, io_wr, io_rd, req} = 4'hF ^ 4'h7;
		{io_addr, exp_irq, pci_irq, io_wdata} = '0;
		repeat (16) @(posedge clk);
		#1 check(io_rdata, 8'h00);
		check(cpu_vector, 8'h00);
		@(posedge clk) rst <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			@(posedge clk) exp_irq[lines[i]] <= 1'b1;
			ack(vecs[i]);
			io_w(16'h00A0, 8'h20);
			io_w(16'h0020, 8'h20);
			@(posedge clk) exp_irq <= 16'h0000;
		end
		@(posedge clk) pci_irq[5] <= 1'b1;
		ack(8'h0D);
		io_w(16'h0020, 8'h0B);
		io_r(16'h0020);
		check(d, 8'h20);
		io_w(16'h0020, 8'h20);
		check({7'h00, cpu_intr}, 8'h01);
		io_r(16'h0020);
		check(d, 8'h00);
		io_r(16'h00E0);
		check({7'h00, d[0]}, 8'h01);
		io_r(16'h00E0);
		check({7'h00, d[0]}, 8'h00);
		ack(8'h0D);
		// source cleared before end of interrupt
		@(posedge clk) pci_irq <= 16'h0000;
		io_w(16'h0020, 8'h20);
		check({7'h00, cpu_intr}, 8'h00);
		io_w(16'h02F1, 8'hFF);
		io_w(16'h06F3, 8'hFF);
		io_r(16'h0021);
		check(d, 8'h00);
		io_r(16'h02F1);
		check(d, 8'h00);
		io_r(16'h0300);
		check(d, 8'h00);
		io_w(16'h0021, 8'h08);
		io_r(16'h0021);
		check(d, 8'h08);
		@(posedge clk) exp_irq[3] <= 1'b1;
		repeat (3) @(posedge clk);
		#1 check({7'h00, cpu_intr}, 8'h00);
		io_w(16'h0021, 8'h00);
		check({7'h00, cpu_intr}, 8'h01);
		ack(8'h0B);
		// Specific end of interrupt; the held edge line must stay quiet
		io_w(16'h0020, 8'h63);
		io_r(16'h0020);
		check(d, 8'h00);
		check({7'h00, cpu_intr}, 8'h00);
		// Request register read shows a masked held level
		io_w(16'h0021, 8'h10);
		@(posedge clk) pci_irq[4] <= 1'b1;
		io_w(16'h0020, 8'h0A);
		io_r(16'h0020);
		check(d, 8'h10);
		check({7'h00, cpu_intr}, 8'h00);
		@(posedge clk) pci_irq <= 16'h0000;
		// Slave re-initialisation with four bytes clears its mask
		io_w(16'h00A1, 8'hFF);
		io_w(16'h00A0, 8'h11);
		io_w(16'h00A1, 8'h70);
		io_w(16'h00A1, 8'h02);
		io_w(16'h00A1, 8'h01);
		io_r(16'h00A1);
		check(d, 8'h00);
		@(posedge clk) exp_irq[9] <= 1'b1;
		ack(8'h71);
		io_w(16'h00A0, 8'h20);
		io_w(16'h0020, 8'h20);
		// Mid-run reset with all lines idle, so no false edge follows it
		@(posedge clk) exp_irq <= 16'h0000;
		@(posedge clk) rst <= 1'b1;
		@(posedge clk) rst <= 1'b0;
		#1 check(cpu_vector, 8'h00);
		check({7'h00, cpu_intr}, 8'h00);
		io_r(16'h00E0);
		check({7'h00, d[0]}, 8'h00);
		conclude();
	end
endmodule // cascaded_interrupt_controller_bench
